// ### verilog/rsl_pkg.sv
// constants and types for the rom strap and eeprom id loader
// Notes on behaviour
// - sample memory strap bus shortly after reset release, then configure rom window and timing
// - size strap 000 gives 16 KB, doubling per step to 110; 111 disables rom
// - every strap pin has a pull-down, an undriven pin samples as zero
// - slow rom strap high adds two clock cycles to each rom access
// - rom window base register reflects strapped size for standard sizing
// - one rom interface is shared by both functions
// - download mode strap applies to each function; each has own id registers
// - in download mode gpio0 is serial data and gpio1 serial clock
// - download reads exactly five eeprom bytes, addresses 0xfb to 0xff
// - 0xfb/0xfc vendor id low/high, 0xfd/0xfe subsystem id low/high
// - sum byte is two's complement of seed 0x55 plus four id bytes; verified
// - no eeprom answer or bad sum leaves both ids reading zero
// - id registers are read-only; host writes have no effect
// - download mode strap high skips download and loads built-in default ids
package rsl_pkg;
  localparam int NUM_FUNC = 2;
  localparam int STRAP_W = 8;
  localparam int SLOW_BIT = 0;
  localparam int SIZE_LSB = 1;
  localparam int SIZE_W = 3;
  localparam int MODE_BIT = 7;
  localparam logic [2:0] SIZE_NONE = 3'h7;
  localparam logic [31:0] ROM_MIN_BYTES = 32'h0000_4000;
  localparam logic [1:0] SLOW_EXTRA = 2'h2;
  localparam logic [1:0] FAST_EXTRA = 2'h0;
  localparam logic [4:0] STRAP_DELAY = 5'h10;
  localparam int CLK_MHZ = 100;
  localparam int SER_RATE_KBPS = 400;
  localparam int QTR_CYC = (CLK_MHZ * 1000 + 4 * SER_RATE_KBPS - 1) / (4 * SER_RATE_KBPS);
  localparam logic [6:0] QTR_LAST = 7'(QTR_CYC - 1);
  localparam logic [7:0] EE_DEV_WR = 8'ha0;
  localparam logic [7:0] EE_DEV_RD = 8'ha1;
  localparam logic [7:0] EE_FIRST_ADDR = 8'hfb;
  localparam logic [7:0] SUM_SEED = 8'h55;
  localparam logic [3:0] SEQ_DEV_WR = 4'h0;
  localparam logic [3:0] SEQ_WORD = 4'h1;
  localparam logic [3:0] SEQ_DEV_RD = 4'h2;
  localparam logic [3:0] SEQ_RD_FIRST = 4'h3;
  localparam logic [3:0] SEQ_RD_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [15:0] ID_ZERO = 16'h0000;
  // arbitrary neutral built-in defaults
  localparam logic [15:0] DFLT_SUBSYS_IDENT = 16'h0c5a;
  localparam logic [15:0] DFLT_SUBSYS_VENDOR = 16'h0c5a;
  typedef enum logic [4:0] {
    FS_IDLE  = 5'h01,
    FS_START = 5'h02,
    FS_BIT   = 5'h04,
    FS_STOP  = 5'h08,
    FS_DONE  = 5'h10
  } rsl_fetch_state_t;
endpackage

// ### verilog/rsl_eeprom_fetch.sv
// two-wire eeprom reader that fetches the five id bytes for one function
`timescale 1ns/1ps
module rsl_eeprom_fetch import rsl_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_sda_i,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_scl_i,
  output logic o_scl_o,
  output logic o_scl_oe,
  output logic o_done,
  output logic o_ok,
  output logic [39:0] o_bytes
);
  rsl_fetch_state_t state_reg;
  logic [2:0] sda_sync_reg, scl_sync_reg;
  logic sda_flt_reg, scl_flt_reg;
  logic [6:0] qcnt_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg, seq_reg;
  logic [7:0] shift_reg, tx_byte, sum;
  logic fail_reg, ack_reg;
  logic tick, reading;

  // pins are asynchronous: filtered value moves only when stages two and three agree
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sda_sync_reg <= 3'h7;
      scl_sync_reg <= 3'h7;
      sda_flt_reg <= 1'b1;
      scl_flt_reg <= 1'b1;
    end else if (i_ce) begin
      sda_sync_reg <= {sda_sync_reg[1:0], i_sda_i};
      scl_sync_reg <= {scl_sync_reg[1:0], i_scl_i};
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_flt_reg <= sda_sync_reg[2];
      end
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_flt_reg <= scl_sync_reg[2];
      end
    end
  end

  // quarter-bit timer, 400 kbit/s is the fastest the eeprom must take
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      qcnt_reg <= QTR_LAST;
    end else if (i_ce) begin
      qcnt_reg <= (qcnt_reg == 7'h00 || state_reg == FS_IDLE) ? QTR_LAST : qcnt_reg - 7'h01;
    end
  end
  assign tick = (qcnt_reg == 7'h00);
  assign reading = (seq_reg >= SEQ_RD_FIRST);

  always_comb begin
    tx_byte = EE_DEV_RD;
    if (seq_reg == SEQ_DEV_WR) begin
      tx_byte = EE_DEV_WR;
    end else if (seq_reg == SEQ_WORD) begin
      tx_byte = EE_FIRST_ADDR;
    end
  end

  // random-address read followed by a five-byte sequential read
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= FS_IDLE;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      seq_reg <= SEQ_DEV_WR;
      shift_reg <= 8'h00;
      fail_reg <= 1'b0;
      ack_reg <= 1'b0;
      o_bytes <= 40'h0;
      o_sda_oe <= 1'b0;
      o_scl_oe <= 1'b0;
    end else if (i_ce) begin
      unique case (state_reg)
        FS_IDLE: begin
          if (i_start) begin
            state_reg <= FS_START;
            q_reg <= 2'h0;
          end
        end
        FS_START: begin
          // a stretched clock must be high again before sda falls, or no restart is seen
          if (tick && !(q_reg == 2'h2 && !scl_flt_reg)) begin
            q_reg <= q_reg + 2'h1;
            unique case (q_reg)
              2'h0: begin
                o_sda_oe <= 1'b0;
              end
              2'h1: begin
                o_scl_oe <= 1'b0;
              end
              2'h2: begin
                o_sda_oe <= 1'b1;
              end
              2'h3: begin
                o_scl_oe <= 1'b1;
                state_reg <= FS_BIT;
                bit_reg <= 4'h0;
              end
            endcase
          end
        end
        FS_BIT: begin
          if (tick && !(q_reg == 2'h2 && !scl_flt_reg)) begin
            q_reg <= q_reg + 2'h1;
            unique case (q_reg)
              2'h0: begin
                if (bit_reg == ACK_SLOT) begin
                  o_sda_oe <= reading && seq_reg != SEQ_RD_LAST;
                end else begin
                  o_sda_oe <= !reading && !tx_byte[3'(4'h7 - bit_reg)];
                end
              end
              2'h1: begin
                o_scl_oe <= 1'b0;
              end
              2'h2: begin
                if (bit_reg == ACK_SLOT) begin
                  ack_reg <= !sda_flt_reg;
                end else begin
                  shift_reg <= {shift_reg[6:0], sda_flt_reg};
                end
              end
              2'h3: begin
                o_scl_oe <= 1'b1;
                bit_reg <= bit_reg + 4'h1;
                if (bit_reg == ACK_SLOT) begin
                  bit_reg <= 4'h0;
                  seq_reg <= seq_reg + 4'h1;
                  if (reading) begin
                    o_bytes[8 * (seq_reg - SEQ_RD_FIRST) +: 8] <= shift_reg;
                  end
                  if (!reading && !ack_reg) begin
                    fail_reg <= 1'b1; // no eeprom answered
                    state_reg <= FS_STOP;
                  end else if (seq_reg == SEQ_RD_LAST) begin
                    state_reg <= FS_STOP;
                  end else if (seq_reg == SEQ_WORD) begin
                    state_reg <= FS_START;
                  end
                end
              end
            endcase
          end
        end
        FS_STOP: begin
          if (tick && !(q_reg == 2'h2 && !scl_flt_reg)) begin
            q_reg <= q_reg + 2'h1;
            unique case (q_reg)
              2'h0: begin
                o_sda_oe <= 1'b1;
              end
              2'h1: begin
                o_scl_oe <= 1'b0;
              end
              2'h2: begin
                o_sda_oe <= 1'b0;
              end
              2'h3: begin
                state_reg <= FS_DONE;
              end
            endcase
          end
        end
        FS_DONE: begin
          state_reg <= FS_DONE;
        end
      endcase
    end
  end

  assign sum = SUM_SEED + o_bytes[7:0] + o_bytes[15:8] + o_bytes[23:16] + o_bytes[31:24] + o_bytes[39:32];

  // ok only when every byte written to the eeprom was acknowledged and the sum byte closes to zero
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_done <= 1'b0;
      o_ok <= 1'b0;
      o_sda_o <= 1'b0;
      o_scl_o <= 1'b0;
    end else if (i_ce) begin
      o_done <= (state_reg == FS_DONE);
      o_ok <= (state_reg == FS_DONE) && !fail_reg && sum == 8'h00;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sum_checked_a: assert property (o_ok |-> sum == 8'h00 && !fail_reg)
    else $error("ok raised with bad sum");
  byte_count_a: assert property (seq_reg <= SEQ_RD_LAST + 4'h1)
    else $error("more than five bytes fetched");
  scl_low_edge_a: assert property ($rose(o_sda_oe) && state_reg == FS_BIT |-> o_scl_oe)
    else $error("data changed while clock high");
endmodule

// ### verilog/rsl_cfg_loader.sv
// power-up strap sampling, rom window configuration and per-function id download
`timescale 1ns/1ps
module rsl_cfg_loader import rsl_pkg::*; #(
  parameter int NF = NUM_FUNC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [STRAP_W-1:0] i_memory_strap_bus,
  input wire logic [NF-1:0] i_gpio0_i,
  output logic [NF-1:0] o_gpio0_o,
  output logic [NF-1:0] o_gpio0_oe,
  input wire logic [NF-1:0] i_gpio1_i,
  output logic [NF-1:0] o_gpio1_o,
  output logic [NF-1:0] o_gpio1_oe,
  input wire logic i_rom_base_wr,
  input wire logic [31:0] i_rom_base_wdata,
  output logic [31:0] o_rom_window_base_reg,
  output logic o_rom_present,
  output logic o_rom_enabled,
  output logic [1:0] o_rom_extra_wait,
  input wire logic [NF-1:0] i_rom_req,
  input wire logic i_rom_done,
  output logic [NF-1:0] o_rom_grant,
  output logic [NF*16-1:0] o_subsys_ident,
  output logic [NF*16-1:0] o_subsys_vendor_ident,
  output logic o_strap_valid,
  output logic o_load_done
);
  logic [STRAP_W-1:0] strap_s1_reg, strap_s2_reg, strap_s3_reg, strap_flt_reg;
  logic [4:0] strap_cnt_reg;
  logic [SIZE_W-1:0] rom_size_strap;
  logic slow_rom_strap, download_mode_strap;
  logic [31:0] rom_mask;
  logic [NF-1:0] fetch_start_reg, fetch_done, fetch_ok, id_loaded_reg;
  logic [NF*40-1:0] fetch_bytes;

  // pull-down pads make an unstrapped pin read zero; three-stage filter
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_s1_reg <= 8'h00;
      strap_s2_reg <= 8'h00;
      strap_s3_reg <= 8'h00;
      strap_flt_reg <= 8'h00;
    end else if (i_ce) begin
      strap_s1_reg <= i_memory_strap_bus;
      strap_s2_reg <= strap_s1_reg;
      strap_s3_reg <= strap_s2_reg;
      if (strap_s2_reg == strap_s3_reg) begin
        strap_flt_reg <= strap_s3_reg;
      end
    end
  end

  // wait after release so the filter has settled, then latch once
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_cnt_reg <= 5'h00;
      o_strap_valid <= 1'b0;
      rom_size_strap <= SIZE_NONE;
      slow_rom_strap <= 1'b0;
      download_mode_strap <= 1'b0;
    end else if (i_ce && !o_strap_valid) begin
      strap_cnt_reg <= strap_cnt_reg + 5'h01;
      if (strap_cnt_reg == STRAP_DELAY - 5'h01) begin
        o_strap_valid <= 1'b1;
        rom_size_strap <= strap_flt_reg[SIZE_LSB +: SIZE_W];
        slow_rom_strap <= strap_flt_reg[SLOW_BIT];
        download_mode_strap <= strap_flt_reg[MODE_BIT];
      end
    end
  end

  // window size doubles from 16 KB per step; all-ones means no rom
  always_comb begin
    rom_mask = 32'h0000_0000;
    if (rom_size_strap != SIZE_NONE) begin
      rom_mask = ~((ROM_MIN_BYTES << rom_size_strap) - 32'h0000_0001);
    end
  end

  // host sizing: writing all ones reads back the window mask plus enable bit
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rom_window_base_reg <= 32'h0000_0000;
      o_rom_present <= 1'b0;
      o_rom_enabled <= 1'b0;
      o_rom_extra_wait <= FAST_EXTRA;
    end else if (i_ce) begin
      o_rom_present <= o_strap_valid && rom_size_strap != SIZE_NONE;
      o_rom_enabled <= o_rom_present && o_rom_window_base_reg[0];
      o_rom_extra_wait <= slow_rom_strap ? SLOW_EXTRA : FAST_EXTRA;
      if (i_rom_base_wr && o_rom_present) begin
        o_rom_window_base_reg <= (i_rom_base_wdata & rom_mask) | {31'h0, i_rom_base_wdata[0]};
      end else if (!o_rom_present) begin
        o_rom_window_base_reg <= 32'h0000_0000;
      end
    end
  end

  // single rom port, fixed priority, held until the access ends
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rom_grant <= '0;
    end else if (i_ce) begin
      if (i_rom_done || !o_rom_enabled) begin
        o_rom_grant <= '0;
      end else if (o_rom_grant == '0) begin
        o_rom_grant <= i_rom_req & (~i_rom_req + NF'(1));
      end
    end
  end

  // one reader and one id pair per function
  genvar f;
  for (f = 0; f < NF; f++) begin : g_func
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
        fetch_start_reg[f] <= 1'b0;
        id_loaded_reg[f] <= 1'b0;
        o_subsys_ident[f*16 +: 16] <= ID_ZERO;
        o_subsys_vendor_ident[f*16 +: 16] <= ID_ZERO;
      end else if (i_ce && o_strap_valid && !id_loaded_reg[f]) begin
        if (download_mode_strap) begin
          o_subsys_ident[f*16 +: 16] <= DFLT_SUBSYS_IDENT;
          o_subsys_vendor_ident[f*16 +: 16] <= DFLT_SUBSYS_VENDOR;
          id_loaded_reg[f] <= 1'b1;
        end else begin
          fetch_start_reg[f] <= 1'b1;
          if (fetch_done[f]) begin
            id_loaded_reg[f] <= 1'b1;
            if (fetch_ok[f]) begin
              o_subsys_vendor_ident[f*16 +: 16] <= fetch_bytes[f*40 +: 16];
              o_subsys_ident[f*16 +: 16] <= fetch_bytes[f*40+16 +: 16];
            end
          end
        end
      end
    end

    // gpio0 carries serial data, gpio1 the serial clock
    rsl_eeprom_fetch u_fetch (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_start(fetch_start_reg[f]),
      .i_sda_i(i_gpio0_i[f]),
      .o_sda_o(o_gpio0_o[f]),
      .o_sda_oe(o_gpio0_oe[f]),
      .i_scl_i(i_gpio1_i[f]),
      .o_scl_o(o_gpio1_o[f]),
      .o_scl_oe(o_gpio1_oe[f]),
      .o_done(fetch_done[f]),
      .o_ok(fetch_ok[f]),
      .o_bytes(fetch_bytes[f*40 +: 40])
    );
  end

  // ids only change through the loader; no host write path exists
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_load_done <= 1'b0;
    end else if (i_ce) begin
      o_load_done <= &id_loaded_reg;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence strap_latch_s;
    !o_strap_valid ##1 o_strap_valid;
  endsequence
  strap_delay_a: assert property (strap_latch_s |-> $past(strap_cnt_reg) == STRAP_DELAY - 5'h01)
    else $error("straps latched at wrong time");
  strap_hold_a: assert property (o_strap_valid |=> $stable(rom_size_strap) && $stable(download_mode_strap))
    else $error("straps changed after latch");
  rom_disable_a: assert property (o_strap_valid && rom_size_strap == SIZE_NONE |=>
    !o_rom_present && !o_rom_enabled)
    else $error("rom active with no rom strapped");
  size_mask_a: assert property ((o_rom_window_base_reg & ~rom_mask & 32'hffff_fffe) == 32'h0)
    else $error("base register has bits inside window");
  slow_wait_a: assert property (o_strap_valid ##1 o_strap_valid |->
    o_rom_extra_wait == (slow_rom_strap ? SLOW_EXTRA : FAST_EXTRA))
    else $error("rom wait does not follow slow strap");
  // grant may outlive a dropped enable by the one cycle the clear takes
  grant_single_a: assert property ($onehot0(o_rom_grant) && (o_rom_grant == '0 || $past(o_rom_enabled)))
    else $error("rom port granted badly");
  fail_zero_a: assert property (!download_mode_strap && o_load_done && !(|fetch_ok) |->
    o_subsys_ident == '0)
    else $error("ids not zero after failed download");
  dflt_ids_a: assert property (o_strap_valid && download_mode_strap ##1 1 |=>
    o_subsys_ident[15:0] == DFLT_SUBSYS_IDENT)
    else $error("default ids not loaded");
  load_map_a: assert property (g_func[0].u_fetch.o_ok && id_loaded_reg[0] && !download_mode_strap |->
    o_subsys_vendor_ident[15:0] == fetch_bytes[15:0] && o_subsys_ident[15:0] == fetch_bytes[31:16])
    else $error("id bytes mapped wrongly");
  pins_idle_a: assert property (download_mode_strap && o_strap_valid |->
    o_gpio0_oe == '0 && o_gpio1_oe == '0)
    else $error("serial pins driven outside download");
  ids_frozen_a: assert property (o_load_done |=>
    $stable(o_subsys_ident) && $stable(o_subsys_vendor_ident))
    else $error("id registers changed after load");
endmodule

// ### dv/rsl_ee_model.sv
// behavioural two-wire serial eeprom holding the five id bytes, optional clock stretch
`timescale 1ns/1ps
module rsl_ee_model #(
  parameter int STRETCH_NS = 0
) (
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_present,
  input wire logic [39:0] i_mem,
  output logic o_sda_low,
  output logic o_scl_low,
  output logic [3:0] o_rd_cnt
);
  logic act = 1'b0;
  logic rd = 1'b0;
  logic ackph = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] ptr = 8'h00;
  logic [7:0] cur = 8'h00;
  int nb = 0;
  int wb = 0;
  // bytes 0xfb..0xff sit at i_mem[7:0]..i_mem[39:32]
  function automatic logic [7:0] byte_at(input logic [7:0] a);
    return i_mem[8*int'(a - 8'hfb) +: 8];
  endfunction
  initial begin
    o_sda_low = 1'b0;
    o_scl_low = 1'b0;
    o_rd_cnt = 4'h0;
  end
  // start or restart; an absent part never wakes up
  always @(negedge i_sda) begin
    if (i_scl === 1'b1) begin
      act = i_present;
      rd = 1'b0;
      ackph = 1'b0;
      nb = 0;
      wb = 0;
      o_sda_low = 1'b0;
    end
  end
  always @(posedge i_sda) begin
    if (i_scl === 1'b1) begin
      act = 1'b0;
      o_sda_low = 1'b0;
    end
  end
  always @(posedge i_scl) begin
    if (act && ackph && rd && i_sda) begin
      act = 1'b0; // master nack ends the sequential read
    end else if (act && !ackph && !rd) begin
      sh = {sh[6:0], i_sda};
      nb++;
    end else if (act && !ackph) begin
      nb++;
    end
  end
  // data only moves while the clock is low
  always @(negedge i_scl) begin
    if (act && ackph) begin
      ackph = 1'b0;
      nb = 0;
      o_sda_low = 1'b0;
      if (rd) begin
        ptr = ptr + 8'h01;
        o_rd_cnt = o_rd_cnt + 4'h1;
        cur = byte_at(ptr);
        o_sda_low = ~cur[7];
      end
    end else if (act && nb == 8) begin
      ackph = 1'b1;
      o_sda_low = 1'b0;
      if (!rd && wb == 0 && sh[7:1] != 7'h50) begin
        act = 1'b0;
      end else if (!rd) begin
        o_sda_low = 1'b1;
        if (wb == 0 && sh[0]) begin
          rd = 1'b1; // read address after restart
          ptr = ptr - 8'h01;
        end else if (wb != 0) begin
          ptr = sh; // word address write
        end
        wb++;
      end
    end else if (act && rd) begin
      cur = byte_at(ptr);
      o_sda_low = ~cur[7 - nb];
    end
  end
  // slow part: holds the clock low after each fall, 400 kbit/s otherwise
  always @(negedge i_scl) begin
    if (STRETCH_NS > 0 && act) begin
      o_scl_low = 1'b1;
      #(STRETCH_NS) o_scl_low = 1'b0;
    end
  end
endmodule

// ### dv/tb_rsl_cfg_loader.sv
// self-checking bench for strap sampling, rom window, rom sharing and id download
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin errors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module tb_rsl_cfg_loader import rsl_pkg::*; ;
  localparam int NF = 2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] strap = 8'h00;
  logic [NF-1:0] present = 2'h0;
  logic [39:0] mem [NF] = '{40'h0, 40'h0};
  logic base_wr = 1'b0;
  logic [31:0] base_wdata = 32'h0;
  logic [NF-1:0] rom_req = 2'h0;
  logic rom_done = 1'b0;
  logic saw_oe = 1'b0;
  logic [31:0] seed = 32'h88724222;
  logic [3:0] cnt0 [NF];
  wire [NF-1:0] sda_w, scl_w, dsda_oe, dscl_oe, ee_sda_low, ee_scl_low, sda_o, scl_o;
  wire [3:0] rd_cnt [NF];
  logic [31:0] rom_base;
  logic rom_present, rom_enabled, strap_valid, load_done;
  logic [1:0] extra_wait;
  logic [NF-1:0] grant;
  logic [NF*16-1:0] ident, vendor;
  int errors = 0;
  int n_compared = 0;
  // open-drain lines with pull-ups
  assign sda_w = ~dsda_oe & ~ee_sda_low;
  assign scl_w = ~dscl_oe & ~ee_scl_low;
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (|{dsda_oe, dscl_oe}) saw_oe <= 1'b1;
  end
  rsl_cfg_loader #(.NF(NF)) DUT (
    .i_sys_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_memory_strap_bus(strap),
    .i_gpio0_i(sda_w), .o_gpio0_o(sda_o), .o_gpio0_oe(dsda_oe),
    .i_gpio1_i(scl_w), .o_gpio1_o(scl_o), .o_gpio1_oe(dscl_oe),
    .i_rom_base_wr(base_wr), .i_rom_base_wdata(base_wdata), .o_rom_window_base_reg(rom_base),
    .o_rom_present(rom_present), .o_rom_enabled(rom_enabled), .o_rom_extra_wait(extra_wait),
    .i_rom_req(rom_req), .i_rom_done(rom_done), .o_rom_grant(grant),
    .o_subsys_ident(ident), .o_subsys_vendor_ident(vendor),
    .o_strap_valid(strap_valid), .o_load_done(load_done));
  rsl_ee_model #(.STRETCH_NS(0)) ee0 (.i_scl(scl_w[0]), .i_sda(sda_w[0]), .i_present(present[0]),
    .i_mem(mem[0]), .o_sda_low(ee_sda_low[0]), .o_scl_low(ee_scl_low[0]), .o_rd_cnt(rd_cnt[0]));
  // stretch long enough that the reader's high-phase wait is really exercised
  rsl_ee_model #(.STRETCH_NS(2000)) ee1 (.i_scl(scl_w[1]), .i_sda(sda_w[1]), .i_present(present[1]),
    .i_mem(mem[1]), .o_sda_low(ee_sda_low[1]), .o_scl_low(ee_scl_low[1]), .o_rd_cnt(rd_cnt[1]));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // good contents carry the sum byte, bad ones have it flipped in bit 0
  function automatic logic [39:0] mk_mem(input logic [31:0] r, input logic good);
    logic [7:0] s;
    s = 8'h00 - (SUM_SEED + r[7:0] + r[15:8] + r[23:16] + r[31:24]);
    return {s ^ {7'h0, ~good}, r};
  endfunction
  function automatic logic [31:0] exp_base(input logic [7:0] st, input logic [31:0] wd);
    logic [31:0] span;
    span = ROM_MIN_BYTES << st[3:1];
    return (st[3:1] == SIZE_NONE) ? 32'h0 : ((wd & ~(span - 32'h1)) | {31'h0, wd[0]});
  endfunction
  function automatic logic [31:0] exp_id(input logic [7:0] st, input logic pr, input logic [39:0] m);
    logic [7:0] s;
    s = SUM_SEED + m[7:0] + m[15:8] + m[23:16] + m[31:24] + m[39:32];
    if (st[7]) return {DFLT_SUBSYS_IDENT, DFLT_SUBSYS_VENDOR};
    if (!pr || s != 8'h00) return 32'h0;
    return m[31:0];
  endfunction
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // 0 straps latched, 1 ids loaded, 2 any grant
  task automatic wait_on(input int which, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      if ((which == 0 && strap_valid === 1'b1) || (which == 1 && load_done === 1'b1) ||
          (which == 2 && grant !== 2'h0)) break;
      tick(1);
    end
    if (i == lim) begin
      errors++;
      $display("[ERR] wait %0d timed out", which);
      close_out();
    end
  endtask
  task automatic arb();
    rom_req = 2'h3;
    wait_on(2, 10);
    `CHK("grant_first", 2'h1, grant)
    // function 0 is finished and drops its request, else it would win again
    rom_req = 2'h2;
    rom_done = 1'b1;
    tick(1);
    rom_done = 1'b0;
    `CHK("grant_gap", 2'h0, grant)
    wait_on(2, 10);
    `CHK("grant_next", 2'h2, grant)
    rom_req = 2'h0;
    rom_done = 1'b1;
    tick(1);
    rom_done = 1'b0;
  endtask
  task automatic run(input logic [7:0] st, input logic [NF-1:0] pr, input logic [NF-1:0] good);
    logic [31:0] d;
    logic [15:0] eid, evd;
    logic on;
    strap = st;
    present = pr;
    mem[0] = mk_mem(rnd(), good[0]);
    mem[1] = mk_mem(rnd(), good[1]);
    cnt0 = rd_cnt;
    rst = 1'b1;
    tick(12);
    saw_oe = 1'b0;
    rst = 1'b0;
    wait_on(0, 100);
    tick(3);
    on = (st[3:1] != SIZE_NONE);
    `CHK("rom_present", on, rom_present)
    `CHK("extra_wait", st[0] ? SLOW_EXTRA : FAST_EXTRA, extra_wait)
    d = rnd();
    base_wr = 1'b1;
    base_wdata = d;
    tick(1);
    base_wdata = 32'hffff_ffff;
    `CHK("base_first", exp_base(st, d), rom_base)
    tick(1);
    base_wr = 1'b0;
    `CHK("base_size", exp_base(st, 32'hffff_ffff), rom_base)
    tick(1);
    `CHK("rom_enabled", on, rom_enabled)
    if (on) arb();
    wait_on(1, 40000);
    for (int f = 0; f < NF; f++) begin
      {eid, evd} = exp_id(st, pr[f], mem[f]);
      `CHK("vendor", evd, vendor[f*16 +: 16])
      `CHK("ident", eid, ident[f*16 +: 16])
      if (!st[7] && pr[f]) `CHK("bytes_read", 4'h5, 4'(rd_cnt[f] - cnt0[f]))
    end
    `CHK("pins_used", ~st[7], saw_oe)
    `CHK("pins_out_low", 4'h0, {sda_o, scl_o})
  endtask
  initial begin
    logic [31:0] r;
    logic [2:0] sz;
    // all straps left to their pull-downs: 16 KB, fast, download
    run(8'h00, 2'h3, 2'h3);
    // 1024 KB slow; function 0 has no part, function 1 a bad sum
    run(8'h0d, 2'h2, 2'h1);
    // no rom and no download: defaults, pins quiet
    run(8'h8f, 2'h3, 2'h3);
    r = rnd();
    sz = (r[2:0] == SIZE_NONE) ? 3'h6 : r[2:0];
    run({4'h0, sz, r[3]}, 2'h3, 2'h3);
    close_out();
  end
endmodule
